// *** common/tpc_consts.svh ***
// Register offsets, field positions, reset values and divider counts of the timer block.
`ifndef TPC_CONSTS_SVH
`define TPC_CONSTS_SVH
`define TPC_ADDR_CKCTL    8'h00
`define TPC_TMR_BASE      8'h20
`define TPC_TMR_STRIDE    8'h10
`define TPC_OFF_CTRL      8'h00
`define TPC_OFF_CFG       8'h01
`define TPC_OFF_LOW       8'h02
`define TPC_OFF_HIGH      8'h03
`define TPC_CKCTL_RESET   8'h00
`define TPC_CKCTL_WMASK   8'h1B
`define TPC_CTRL_RESET    8'h00
`define TPC_CTRL_WMASK    8'hCF
`define TPC_CFG_RESET     8'h00
`define TPC_CFG_WMASK     8'h1F
`define TPC_CNT_RESET     16'h0000
`define TPC_CNT_MAX       16'hFFFF
`define TPC_CNT_MIN       16'h0000
`define TPC_CK_T1SEL      4
`define TPC_CK_T0SEL      3
`define TPC_CK_SCA_LO     0
`define TPC_CTL_FLAG      7
`define TPC_CTL_EXTFLAG   6
`define TPC_CTL_EXTEN     3
`define TPC_CTL_RUN       2
`define TPC_CTL_CNTSEL    1
`define TPC_CTL_CAPSEL    0
`define TPC_CFG_CS_LO     3
`define TPC_CFG_TOGST     2
`define TPC_CFG_TOGEN     1
`define TPC_CFG_DECEN     0
`define TPC_SPAN_LAST     6'h2F
`define TPC_DIV12         6'h0C
`define TPC_DIV12_LAST    6'h0B
`define TPC_EXT_LAST      3'h7
`endif

// *** common/tpc_pkg.sv ***
// Types shared by the timer prescale and up/down counter block.
package tpc_pkg;
	typedef enum logic [1:0] {
		TPC_PS_DIV12,
		TPC_PS_DIV4,
		TPC_PS_DIV48,
		TPC_PS_EXT8
	} tpc_prescale_t;
	typedef enum logic [1:0] {
		TPC_CS_DIV12,
		TPC_CS_CORE_SYSTEM_CLOCK,
		TPC_CS_EXT8,
		TPC_CS_DIV2
	} tpc_tmr_clk_t;
endpackage

// *** common/tpc_tick_if.sv ***
// Divided clock ticks passed from the prescaler to the timer logic.
`timescale 1ns/1ps
`default_nettype none
interface tpc_tick_if;
	logic div2;
	logic div4;
	logic div12;
	logic div48;
	logic ext8;
	modport src (output div2, output div4, output div12, output div48, output ext8);
	modport snk (input div2, input div4, input div12, input div48, input ext8);
endinterface
`default_nettype wire

// *** src/tpc_pin_sync.sv ***
// Two-stage synchroniser with edge detection for asynchronous pins.
`timescale 1ns/1ps
`default_nettype none
module tpc_pin_sync #(
	parameter int unsigned WIDTH = 1
) (
	// Clock and reset
	input  wire logic             i_sys_clk,
	input  wire logic             i_resetn,
	// Pins and their synchronised views
	input  wire logic [WIDTH-1:0] i_pin,
	output logic      [WIDTH-1:0] o_level,
	output logic      [WIDTH-1:0] o_fall,
	output logic      [WIDTH-1:0] o_rise
);
	logic [WIDTH-1:0] meta_q, meta_d;
	logic [WIDTH-1:0] sync_q, sync_d;
	logic [WIDTH-1:0] prev_q, prev_d;

	always_comb begin
		meta_d = i_pin;
		sync_d = meta_q;
		prev_d = sync_q;
	end

	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			meta_q <= '1;
			sync_q <= '1;
			prev_q <= '1;
		end else begin
			meta_q <= meta_d;
			sync_q <= sync_d;
			prev_q <= prev_d;
		end
	end

	// Comparing two settled samples gives exactly one pulse per edge.
	assign o_level = sync_q;
	assign o_fall  = prev_q & ~sync_q;
	assign o_rise  = ~prev_q & sync_q;
endmodule
`default_nettype wire

// *** src/tpc_prescaler.sv ***
// Free-running divider producing the shared prescaled clock ticks.
`timescale 1ns/1ps
`default_nettype none
module tpc_prescaler import tpc_pkg::*; (
	// Clock and reset
	input  wire logic i_sys_clk,
	input  wire logic i_resetn,
	// External oscillator pin
	input  wire logic i_ext_osc,
	// Tick outputs
	tpc_tick_if.src   tk
);
	`include "tpc_consts.svh"

	logic [5:0] span_q, span_d;
	logic [2:0] ext_q, ext_d;
	logic       ext_rise;

	tpc_pin_sync #(.WIDTH(1)) u_ext_sync (
		.i_sys_clk (i_sys_clk),
		.i_resetn  (i_resetn),
		.i_pin     (i_ext_osc),
		.o_level   (),
		.o_fall    (),
		.o_rise    (ext_rise)
	);

	always_comb begin
		span_d = (span_q == `TPC_SPAN_LAST) ? 6'h00 : span_q + 6'h01;
		ext_d  = ext_rise ? ext_q + 3'h1 : ext_q;
	end

	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			span_q <= 6'h00;
			ext_q  <= 3'h0;
		end else begin
			span_q <= span_d;
			ext_q  <= ext_d;
		end
	end

	// One span of 48 cycles serves every system divider, so the ticks stay in phase.
	assign tk.div2  = span_q[0];
	assign tk.div4  = (span_q[1:0] == 2'h3);
	assign tk.div12 = ((span_q % `TPC_DIV12) == `TPC_DIV12_LAST);
	assign tk.div48 = (span_q == `TPC_SPAN_LAST);
	assign tk.ext8  = ext_rise && (ext_q == `TPC_EXT_LAST);
endmodule
`default_nettype wire

// *** src/tpc_top.sv ***
// Timer 0/1 clock selection and the 16-bit up/down counters of timers 2 to 4.
`timescale 1ns/1ps
`default_nettype none
module tpc_top import tpc_pkg::*; (
	// Clock and reset
	input  wire logic       i_sys_clk,
	input  wire logic       i_resetn,
	// Special-function register port
	input  wire logic [7:0] i_sfr_addr,
	input  wire logic [7:0] i_sfr_wdata,
	input  wire logic       i_sfr_wr,
	input  wire logic       i_sfr_rd,
	output logic      [7:0] o_sfr_rdata,
	// Timer 0 and 1 clocking
	input  wire logic       i_timer_zero_counter_select,
	input  wire logic       i_timer_one_counter_select,
	input  wire logic       i_t0_count_input_pin,
	input  wire logic       i_t1_count_input_pin,
	output logic            o_t0_tick,
	output logic            o_t1_tick,
	// Timers 2 to 4 pins
	input  wire logic [2:0] i_count_input_pin,
	input  wire logic [2:0] i_direction_capture_input,
	input  wire logic       i_ext_osc,
	// Events and status
	input  wire logic       i_t1_overflow,
	output logic      [2:0] o_overflow,
	output logic      [2:0] o_ext_event,
	output logic      [2:0] o_capture_mode,
	output logic      [2:0] o_toggle_enable,
	output logic      [2:0] o_toggle_out,
	output logic      [3:0] o_uart0_baud_ovf,
	output logic      [1:0] o_uart1_baud_ovf
);
	`include "tpc_consts.svh"

	localparam int unsigned NT = 3;

	logic [7:0]  ckctl_q, ckctl_d;
	logic [7:0]  ctrl_q [NT];
	logic [7:0]  ctrl_d [NT];
	logic [7:0]  cfg_q [NT];
	logic [7:0]  cfg_d [NT];
	logic [15:0] cnt_q [NT];
	logic [15:0] cnt_d [NT];
	logic [7:0]  rdata_q, rdata_d;
	logic        t0_tick_q, t0_tick_d;
	logic        t1_tick_q, t1_tick_d;
	logic        t1_ovf_q, t1_ovf_d;
	logic [2:0]  ovf_q, ovf_d;
	logic [2:0]  evt_q, evt_d;
	logic [2:0]  step, up, wrap, ext_evt;
	logic [7:0]  pin_lvl, pin_fall;

	tpc_tick_if tk ();

	tpc_prescaler u_pre (
		.i_sys_clk (i_sys_clk),
		.i_resetn  (i_resetn),
		.i_ext_osc (i_ext_osc),
		.tk        (tk)
	);

	// Bit order: t0, t1, count pins of timers 2-4, direction pins of timers 2-4.
	tpc_pin_sync #(.WIDTH(8)) u_pin_sync (
		.i_sys_clk (i_sys_clk),
		.i_resetn  (i_resetn),
		.i_pin     ({i_direction_capture_input, i_count_input_pin,
			i_t1_count_input_pin, i_t0_count_input_pin}),
		.o_level   (pin_lvl),
		.o_fall    (pin_fall),
		.o_rise    ()
	);

	function automatic logic tmr_hit(input logic [7:0] a, input int unsigned n,
		input logic [7:0] off);
		return a == 8'(`TPC_TMR_BASE + n * `TPC_TMR_STRIDE + off);
	endfunction

	function automatic logic prescaled(input logic [1:0] sca);
		case (tpc_prescale_t'(sca))
			TPC_PS_DIV12: return tk.div12;
			TPC_PS_DIV4:  return tk.div4;
			TPC_PS_DIV48: return tk.div48;
			default:      return tk.ext8;
		endcase
	endfunction

	function automatic logic tmr_clk(input logic [1:0] sel);
		case (tpc_tmr_clk_t'(sel))
			TPC_CS_DIV12:  return tk.div12;
			TPC_CS_CORE_SYSTEM_CLOCK: return 1'b1;
			TPC_CS_EXT8:   return tk.ext8;
			default:       return tk.div2;
		endcase
	endfunction

	// Timer 0 and 1 clock selection; the pin path overrides the select bits.
	always_comb begin
		if (i_timer_zero_counter_select) begin
			t0_tick_d = pin_fall[0];
		end else if (ckctl_q[`TPC_CK_T0SEL]) begin
			t0_tick_d = 1'b1;
		end else begin
			t0_tick_d = prescaled(ckctl_q[`TPC_CK_SCA_LO +: 2]);
		end
		if (i_timer_one_counter_select) begin
			t1_tick_d = pin_fall[1];
		end else if (ckctl_q[`TPC_CK_T1SEL]) begin
			t1_tick_d = 1'b1;
		end else begin
			t1_tick_d = prescaled(ckctl_q[`TPC_CK_SCA_LO +: 2]);
		end
		t1_ovf_d = i_t1_overflow;
	end

	// Clock-control register; unused bits are never stored.
	always_comb begin
		ckctl_d = ckctl_q;
		if (i_sfr_wr && i_sfr_addr == `TPC_ADDR_CKCTL) begin
			ckctl_d = i_sfr_wdata & `TPC_CKCTL_WMASK;
		end
	end

	// Counters of timers 2 to 4. A hardware flag set wins over a software
	// write in the same cycle, so no event is lost.
	always_comb begin
		for (int i = 0; i < NT; i++) begin
			if (ctrl_q[i][`TPC_CTL_CNTSEL]) begin
				step[i] = ctrl_q[i][`TPC_CTL_RUN] && pin_fall[2 + i];
			end else begin
				step[i] = ctrl_q[i][`TPC_CTL_RUN] &&
					tmr_clk(cfg_q[i][`TPC_CFG_CS_LO +: 2]);
			end
			up[i] = !cfg_q[i][`TPC_CFG_DECEN] || pin_lvl[5 + i];
			wrap[i] = step[i] &&
				(up[i] ? cnt_q[i] == `TPC_CNT_MAX : cnt_q[i] == `TPC_CNT_MIN);
			ext_evt[i] = ctrl_q[i][`TPC_CTL_EXTEN] &&
				!cfg_q[i][`TPC_CFG_DECEN] && pin_fall[5 + i];
			cnt_d[i] = cnt_q[i];
			if (step[i]) begin
				cnt_d[i] = up[i] ? cnt_q[i] + 16'h0001 : cnt_q[i] - 16'h0001;
			end
			if (i_sfr_wr && tmr_hit(i_sfr_addr, i, `TPC_OFF_LOW)) begin
				cnt_d[i][7:0] = i_sfr_wdata;
			end
			if (i_sfr_wr && tmr_hit(i_sfr_addr, i, `TPC_OFF_HIGH)) begin
				cnt_d[i][15:8] = i_sfr_wdata;
			end
			ctrl_d[i] = ctrl_q[i];
			if (i_sfr_wr && tmr_hit(i_sfr_addr, i, `TPC_OFF_CTRL)) begin
				ctrl_d[i] = i_sfr_wdata & `TPC_CTRL_WMASK;
			end
			if (wrap[i]) begin
				ctrl_d[i][`TPC_CTL_FLAG] = 1'b1;
			end
			if (ext_evt[i]) begin
				ctrl_d[i][`TPC_CTL_EXTFLAG] = 1'b1;
			end
			cfg_d[i] = cfg_q[i];
			if (i_sfr_wr && tmr_hit(i_sfr_addr, i, `TPC_OFF_CFG)) begin
				cfg_d[i] = i_sfr_wdata & `TPC_CFG_WMASK;
			end
			if (wrap[i] && cfg_q[i][`TPC_CFG_TOGEN]) begin
				cfg_d[i][`TPC_CFG_TOGST] = ~cfg_q[i][`TPC_CFG_TOGST];
			end
			ovf_d[i] = wrap[i];
			evt_d[i] = ext_evt[i];
		end
	end

	// Read data is captured on the read strobe and holds until the next read.
	always_comb begin
		rdata_d = rdata_q;
		if (i_sfr_rd) begin
			rdata_d = 8'h00;
			if (i_sfr_addr == `TPC_ADDR_CKCTL) begin
				rdata_d = ckctl_q;
			end
			for (int i = 0; i < NT; i++) begin
				if (tmr_hit(i_sfr_addr, i, `TPC_OFF_CTRL)) begin
					rdata_d = ctrl_q[i];
				end else if (tmr_hit(i_sfr_addr, i, `TPC_OFF_CFG)) begin
					rdata_d = cfg_q[i];
				end else if (tmr_hit(i_sfr_addr, i, `TPC_OFF_LOW)) begin
					rdata_d = cnt_q[i][7:0];
				end else if (tmr_hit(i_sfr_addr, i, `TPC_OFF_HIGH)) begin
					rdata_d = cnt_q[i][15:8];
				end
			end
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			ckctl_q   <= `TPC_CKCTL_RESET;
			rdata_q   <= 8'h00;
			t0_tick_q <= 1'b0;
			t1_tick_q <= 1'b0;
			t1_ovf_q  <= 1'b0;
			ovf_q     <= 3'h0;
			evt_q     <= 3'h0;
			for (int i = 0; i < NT; i++) begin
				ctrl_q[i] <= `TPC_CTRL_RESET;
				cfg_q[i]  <= `TPC_CFG_RESET;
				cnt_q[i]  <= `TPC_CNT_RESET;
			end
		end else begin
			ckctl_q   <= ckctl_d;
			rdata_q   <= rdata_d;
			t0_tick_q <= t0_tick_d;
			t1_tick_q <= t1_tick_d;
			t1_ovf_q  <= t1_ovf_d;
			ovf_q     <= ovf_d;
			evt_q     <= evt_d;
			for (int i = 0; i < NT; i++) begin
				ctrl_q[i] <= ctrl_d[i];
				cfg_q[i]  <= cfg_d[i];
				cnt_q[i]  <= cnt_d[i];
			end
		end
	end

	assign o_sfr_rdata = rdata_q;
	assign o_t0_tick   = t0_tick_q;
	assign o_t1_tick   = t1_tick_q;
	assign o_overflow  = ovf_q;
	assign o_ext_event = evt_q;
	// Serial port 1 may take timers 2 and 3; serial port 0 timers 1 to 4.
	assign o_uart1_baud_ovf = ovf_q[1:0];
	assign o_uart0_baud_ovf = {ovf_q, t1_ovf_q};
	always_comb begin
		for (int i = 0; i < NT; i++) begin
			o_capture_mode[i]  = ctrl_q[i][`TPC_CTL_CAPSEL];
			o_toggle_enable[i] = cfg_q[i][`TPC_CFG_TOGEN];
			o_toggle_out[i]    = cfg_q[i][`TPC_CFG_TOGST];
		end
	end

	default clocking cb @(posedge i_sys_clk);
	endclocking
	default disable iff (!i_resetn);

	a_ckctl_upper_zero: assert property (ckctl_q[7:5] == 3'h0)
		else $error("clock control upper bits not zero");
	a_ckctl_bit2_zero: assert property (
		(i_sfr_rd && i_sfr_addr == `TPC_ADDR_CKCTL) |=> !o_sfr_rdata[2])
		else $error("clock control bit 2 read as one");

	sequence s_t1_pin_fall;
		i_timer_one_counter_select && pin_fall[1];
	endsequence
	a_t1_pin_tick: assert property (s_t1_pin_fall |=> o_t1_tick)
		else $error("timer 1 missed a pin edge");
	a_t1_pin_only: assert property (
		i_timer_one_counter_select && !pin_fall[1] |=> !o_t1_tick)
		else $error("timer 1 ticked without a pin edge");
	a_t0_core_system_clock: assert property (
		!i_timer_zero_counter_select && ckctl_q[`TPC_CK_T0SEL] |=> o_t0_tick)
		else $error("timer 0 not on system clock");
	a_t0_div4_gap: assert property (
		!i_timer_zero_counter_select && ckctl_q[7:0] == 8'h01 && tk.div4
		##1 ckctl_q == 8'h01 |=> !o_t0_tick [*3])
		else $error("timer 0 divide by 4 ticked early");

	for (genvar g = 0; g < NT; g++) begin : g_chk
		sequence s_quiet;
			!i_sfr_wr;
		endsequence
		a_count_up_step: assert property (
			((step[g] && up[g]) and s_quiet) |=> cnt_q[g] == $past(cnt_q[g]) + 16'h0001)
			else $error("counter did not step up");
		a_dir_follows_pin: assert property (
			cfg_q[g][`TPC_CFG_DECEN] |-> up[g] == pin_lvl[5 + g])
			else $error("direction does not follow the pin");
		a_dir_no_event: assert property (
			cfg_q[g][`TPC_CFG_DECEN] |=> !o_ext_event[g])
			else $error("direction pin raised an event");
		a_underflow_flag: assert property (
			((step[g] && !up[g] && cnt_q[g] == 16'h0000) and s_quiet)
			|=> cnt_q[g] == 16'hFFFF && ctrl_q[g][`TPC_CTL_FLAG] && o_overflow[g])
			else $error("underflow not flagged");
		a_clk_sel_core_system_clock: assert property (
			ctrl_q[g][`TPC_CTL_RUN] && !ctrl_q[g][`TPC_CTL_CNTSEL]
			&& cfg_q[g][4:3] == 2'h1 |-> step[g])
			else $error("undivided clock select did not step");
	end
endmodule
`default_nettype wire

// *** dv/tpc_pin_model.sv ***
// Model of the external count, direction and oscillator pins around the timer block.
`timescale 1ns/1ps
`default_nettype none
module tpc_pin_model (
	// Clock used to pace pin activity
	input  wire logic       i_sys_clk,
	// Pins driven into the block
	output logic      [2:0] o_count_pin,
	output logic      [2:0] o_dir_pin,
	output logic            o_t0_pin,
	output logic            o_t1_pin,
	output var logic        o_ext_osc
);
	logic [7:0] pins;
	assign o_count_pin = pins[2:0];
	assign o_t0_pin    = pins[3];
	assign o_t1_pin    = pins[4];
	// Direction pins are plain digital inputs, held at a steady level between changes.
	assign o_dir_pin   = pins[7:5];
	// The oscillator runs free at an offset phase so its edges never meet the clock edge.
	initial begin
		pins      = 8'hFF;
		o_ext_osc = 1'b0;
		#1.3;
		forever #4 o_ext_osc = ~o_ext_osc;
	end
	// Each low phase lasts three cycles so the synchroniser cannot miss it.
	task automatic pulse(input int sel, input int n);
		repeat (n) begin
			@(negedge i_sys_clk);
			pins[sel] = 1'b0;
			repeat (3) @(negedge i_sys_clk);
			pins[sel] = 1'b1;
			repeat (2) @(negedge i_sys_clk);
		end
	endtask
	task automatic set_dir(input int idx, input logic lvl);
		@(negedge i_sys_clk);
		pins[5 + idx] = lvl;
	endtask
endmodule
`default_nettype wire

// *** dv/tb_top.sv ***
// Self-checking testbench of the timer prescale and up/down counter block.
`timescale 1ns/1ps
`default_nettype none
`include "tpc_consts.svh"
module tb_top;
	import tpc_pkg::*;
	logic        sys_clk = 1'b0;
	logic        resetn  = 1'b0;
	logic [7:0]  addr    = 8'h00;
	logic [7:0]  wdata   = 8'h00;
	logic        wr      = 1'b0;
	logic        rd      = 1'b0;
	logic        c0sel   = 1'b0;
	logic        c1sel   = 1'b0;
	logic        t1ovf   = 1'b0;
	wire  [7:0]  rdata;
	wire  [2:0]  cnt_pin;
	wire  [2:0]  dir_pin;
	wire         t0_pin;
	wire         t1_pin;
	wire         ext_osc;
	wire         t0_tick;
	wire         t1_tick;
	wire  [2:0]  ovf;
	wire  [2:0]  ext_ev;
	wire  [2:0]  cap_mode;
	wire  [2:0]  tog_en;
	wire  [2:0]  tog_out;
	wire  [3:0]  u0_ovf;
	wire  [1:0]  u1_ovf;
	int          num_errors  = 0;
	int          check_count = 0;
	int          n_ov        = 0;
	int          n_u0        = 0;
	int          n_u1        = 0;
	int          n_ev        = 0;
	logic [7:0]  r;
	logic [7:0]  a;
	logic [7:0]  b;
	logic [7:0]  v;
	logic [15:0] n0;
	logic [15:0] n1;
	int          n;
	int          m;
	int          k;

	always #2 sys_clk = ~sys_clk;

	tpc_pin_model u_pins (.i_sys_clk(sys_clk), .o_count_pin(cnt_pin), .o_dir_pin(dir_pin),
		.o_t0_pin(t0_pin), .o_t1_pin(t1_pin), .o_ext_osc(ext_osc));

	tpc_top DUT (.i_sys_clk(sys_clk), .i_resetn(resetn), .i_sfr_addr(addr),
		.i_sfr_wdata(wdata), .i_sfr_wr(wr), .i_sfr_rd(rd), .o_sfr_rdata(rdata),
		.i_timer_zero_counter_select(c0sel), .i_timer_one_counter_select(c1sel),
		.i_t0_count_input_pin(t0_pin), .i_t1_count_input_pin(t1_pin),
		.o_t0_tick(t0_tick), .o_t1_tick(t1_tick), .i_count_input_pin(cnt_pin),
		.i_direction_capture_input(dir_pin), .i_ext_osc(ext_osc), .i_t1_overflow(t1ovf),
		.o_overflow(ovf), .o_ext_event(ext_ev), .o_capture_mode(cap_mode),
		.o_toggle_enable(tog_en), .o_toggle_out(tog_out), .o_uart0_baud_ovf(u0_ovf),
		.o_uart1_baud_ovf(u1_ovf));

	// Pulse counters let wrap events be compared against the baud outputs at the end.
	always @(posedge sys_clk) begin
		if (ovf[0] === 1'b1) n_ov++;
		if (u0_ovf[1] === 1'b1) n_u0++;
		if (u1_ovf[0] === 1'b1) n_u1++;
		if (ext_ev[2] === 1'b1) n_ev++;
	end

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic wreg(input logic [7:0] ad, input logic [7:0] d);
		@(negedge sys_clk);
		addr  = ad;
		wdata = d;
		wr    = 1'b1;
		@(negedge sys_clk);
		wr    = 1'b0;
	endtask
	task automatic rreg(input logic [7:0] ad, output logic [7:0] d);
		@(negedge sys_clk);
		addr = ad;
		rd   = 1'b1;
		@(negedge sys_clk);
		rd   = 1'b0;
		@(posedge sys_clk);
		#1 d = rdata;
	endtask
	task automatic count_ticks(output logic [15:0] c0, output logic [15:0] c1);
		c0 = 16'h0000;
		c1 = 16'h0000;
		repeat (3) @(posedge sys_clk);
		repeat (96) begin
			@(posedge sys_clk);
			#1 c0 = c0 + 16'(t0_tick === 1'b1);
			c1 = c1 + 16'(t1_tick === 1'b1);
		end
	endtask
	function automatic logic [7:0] ta(input int i, input logic [7:0] off);
		return `TPC_TMR_BASE + `TPC_TMR_STRIDE * 8'(i) + off;
	endfunction
	function automatic int ps_div(input int c);
		return (c == 0) ? 12 : (c == 1) ? 4 : (c == 2) ? 48 : 16;
	endfunction
	function automatic int cs_div(input int c);
		return (c == 0) ? 12 : (c == 1) ? 1 : (c == 2) ? 16 : 2;
	endfunction
	task automatic print_verdict();
		$display("checks=%0d errors=%0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	initial begin
		#80000;
		num_errors++;
		print_verdict();
	end

	initial begin
		void'($urandom(32'h775C));
		repeat (5) @(negedge sys_clk);
		resetn = 1'b1;
		rreg(8'h00, r);
		chk(r, 8'h00);
		wreg(8'h00, 8'hFF);
		rreg(8'h00, r);
		chk(r, 8'h1B);
		wreg(8'h10, 8'hA5);
		rreg(8'h10, r);
		chk(r, 8'h00);
		for (int i = 0; i < 3; i++) begin
			for (int j = 0; j < 4; j++) begin
				rreg(ta(i, 8'(j)), r);
				chk(r, 8'h00);
			end
			for (int j = 2; j < 4; j++) begin
				v = 8'($urandom);
				wreg(ta(i, 8'(j)), v);
				rreg(ta(i, 8'(j)), r);
				chk(r, v);
			end
			v = 8'($urandom) & 8'h1F;
			wreg(ta(i, 1), v);
			rreg(ta(i, 1), r);
			chk(r, v);
			chk(tog_en[i], v[1]);
			chk(tog_out[i], v[2]);
			v = 8'($urandom) & 8'h0B;
			wreg(ta(i, 0), v);
			rreg(ta(i, 0), r);
			chk(r, v);
			chk(cap_mode[i], v[0]);
			wreg(ta(i, 0), 8'h00);
			wreg(ta(i, 1), 8'h00);
		end
		$display("test registers done");
		for (int c = 0; c < 4; c++) begin
			wreg(8'h00, 8'(c) | 8'h10);
			count_ticks(n0, n1);
			chk(n0, 16'(96 / ps_div(c)));
			chk(n1, 16'd96);
			wreg(8'h00, 8'(c) | 8'h08);
			count_ticks(n0, n1);
			chk(n0, 16'd96);
			chk(n1, 16'(96 / ps_div(c)));
		end
		n = $urandom_range(12, 1);
		wreg(8'h00, 8'h18);
		@(negedge sys_clk);
		c0sel = 1'b1;
		fork
			count_ticks(n0, n1);
			u_pins.pulse(3, n);
		join
		chk(n0, 16'(n));
		@(negedge sys_clk);
		c0sel = 1'b0;
		c1sel = 1'b1;
		fork
			count_ticks(n0, n1);
			u_pins.pulse(4, n);
		join
		chk(n1, 16'(n));
		chk(n0, 16'd96);
		@(negedge sys_clk);
		c1sel = 1'b0;
		$display("test prescaler done");
		for (int c = 0; c < 4; c++) begin
			wreg(ta(0, 2), 8'h00);
			wreg(ta(0, 1), 8'(c) << 3);
			wreg(ta(0, 0), 8'h04);
			rreg(ta(0, 2), a);
			repeat (46) @(negedge sys_clk);
			rreg(ta(0, 2), b);
			wreg(ta(0, 0), 8'h00);
			chk(8'(b - a), 16'(48 / cs_div(c)));
		end
		$display("test clock select done");
		n = $urandom_range(15, 1);
		m = $urandom_range(n, 0);
		wreg(ta(1, 2), 8'h00);
		wreg(ta(1, 3), 8'h00);
		wreg(ta(1, 0), 8'h06);
		u_pins.pulse(1, n);
		repeat (4) @(negedge sys_clk);
		rreg(ta(1, 2), a);
		chk(a, 16'(n));
		u_pins.set_dir(1, 1'b0);
		wreg(ta(1, 1), 8'h01);
		u_pins.pulse(1, m);
		repeat (4) @(negedge sys_clk);
		rreg(ta(1, 2), a);
		chk(a, 16'(n - m));
		wreg(ta(1, 0), 8'h00);
		u_pins.set_dir(1, 1'b1);
		$display("test pin counting done");
		for (int d = 0; d < 2; d++) begin
			u_pins.set_dir(0, d[0]);
			wreg(ta(0, 2), d[0] ? 8'hFE : 8'h01);
			wreg(ta(0, 3), d[0] ? 8'hFF : 8'h00);
			wreg(ta(0, 1), 8'h09);
			wreg(ta(0, 0), 8'h04);
			k = 0;
			while (ovf[0] !== 1'b1 && k < 20) begin
				@(posedge sys_clk);
				#1 k++;
			end
			chk(ovf[0], 1'b1);
			rreg(ta(0, 0), r);
			chk(r, 8'h84);
			wreg(ta(0, 0), 8'h00);
			rreg(ta(0, 3), r);
			chk(r, d[0] ? 8'h00 : 8'hFF);
		end
		$display("test wrap done");
		wreg(ta(2, 0), 8'h08);
		wreg(ta(2, 1), 8'h01);
		u_pins.pulse(7, 1);
		repeat (4) @(negedge sys_clk);
		rreg(ta(2, 0), r);
		chk(r, 8'h08);
		wreg(ta(2, 1), 8'h00);
		u_pins.pulse(7, 1);
		repeat (4) @(negedge sys_clk);
		rreg(ta(2, 0), r);
		chk(r, 8'h48);
		chk(16'(n_ev), 16'd1);
		$display("test direction pin done");
		@(negedge sys_clk);
		t1ovf = 1'b1;
		@(negedge sys_clk);
		t1ovf = 1'b0;
		chk(u0_ovf[0], 1'b1);
		@(negedge sys_clk);
		chk(u0_ovf[0], 1'b0);
		chk(16'(n_ov), 16'd2);
		chk(16'(n_u0), 16'(n_ov));
		chk(16'(n_u1), 16'(n_ov));
		$display("test baud sources done");
		print_verdict();
	end
endmodule
`default_nettype wire
